// ==== hdl/rfc_pkg.sv ====
// rfc_pkg: register map, field positions and reset values for the
// front-end pin and frequency-hop control block.
// assumes 8-bit registers on a 7-bit address, single 10 MHz clock.
package rfc_pkg;
  localparam int RFC_ADDR_W = 7;
  localparam int RFC_DATA_W = 8;
  localparam int RFC_CHAN_W = 24;

  // register addresses
  localparam logic [6:0] RFC_MAIN_ADDR = 7'h00;
  localparam logic [6:0] RFC_IFACE_ADDR = 7'h01;
  localparam logic [6:0] RFC_RESET_ADDR = 7'h02;
  localparam logic [6:0] RFC_FREQ2A_ADDR = 7'h04;
  localparam logic [6:0] RFC_FREQ1A_ADDR = 7'h05;
  localparam logic [6:0] RFC_FREQ0A_ADDR = 7'h06;
  localparam logic [6:0] RFC_FREQ2B_ADDR = 7'h08;
  localparam logic [6:0] RFC_FREQ1B_ADDR = 7'h09;
  localparam logic [6:0] RFC_FREQ0B_ADDR = 7'h0A;
  localparam logic [6:0] RFC_LOCK_ADDR = 7'h15;
  localparam logic [6:0] RFC_OFFSET_ADDR = 7'h46;
  localparam logic [6:0] RFC_CP_STAT_ADDR = 7'h48;
  localparam logic [6:0] RFC_OA_STAT_ADDR = 7'h49;
  localparam logic [6:0] RFC_OB_STAT_ADDR = 7'h4A;
  localparam logic [6:0] RFC_CP_FORCE_ADDR = 7'h4B;
  localparam logic [6:0] RFC_OA_FORCE_ADDR = 7'h4C;
  localparam logic [6:0] RFC_OB_FORCE_ADDR = 7'h4D;

  // field positions
  localparam int RFC_MAIN_FSEL_BIT = 6;
  localparam int RFC_IF_TX_AUTO_BIT = 0;
  localparam int RFC_IF_RX_AUTO_BIT = 1;
  localparam int RFC_IF_TX_POL_BIT = 2;
  localparam int RFC_IF_RX_POL_BIT = 3;
  localparam int RFC_IF_DATA_CLOCK_PIN_LOCK_BIT = 4;
  localparam int RFC_RESET_GO_BIT = 0;
  localparam int RFC_CP_W = 4;
  localparam int RFC_OA_W = 5;
  localparam int RFC_OB_W = 6;
  localparam int RFC_OA_FORCE_EN_BIT = 5;
  localparam int RFC_CP_FORCE_EN_BIT = 6;
  localparam int RFC_OB_FORCE_EN_BIT = 6;
  localparam int RFC_LOCK_SEL_W = 4;

  // reset values
  localparam logic [7:0] RFC_REG_RST = 8'h00;
  localparam logic [23:0] RFC_CHAN_RST = 24'h00_0000;

  // lock pin source encodings
  localparam logic [3:0] RFC_LOCK_LOW = 4'h0;
  localparam logic [3:0] RFC_LOCK_HIGH = 4'h1;
  localparam logic [3:0] RFC_LOCK_SYNTH = 4'h2;
endpackage : rfc_pkg

// ==== hdl/rfc_sync2.sv ====
// rfc_sync2: two-flop synchroniser for signals from the analog side.
// assumes inputs are quasi-static levels; no pulse capture.
`timescale 1ns/1ps
module rfc_sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule : rfc_sync2

// ==== hdl/rfc_frontend.sv ====
// rfc_frontend: front-end control pins, lock pin, dual channel words,
// calibration status and override registers of the transceiver.
// assumes a synchronous 8-bit register port and analog status levels
// that are asynchronous to clock_in.
// How it works
// - tx auto bit set: tx control pin active while transmit amplifier on
// - rx auto bit set: rx control pin active while low-noise amplifier on
// - polarity bits choose active-high or active-low for auto-following pins
// - auto bit clear: pin simply copies its written polarity bit
// - lock select 0000 drives lock pin low, 0001 drives it high
// - two channel words; main bit 6 picks the one driving synthesizer
// - calibration results readable: charge pump 3:0, array 4:0, bias 5:0
// - force registers replace calibration results; array and bias use own enable bits, charge pump is enabled by array force bit 6
// - measured carrier offset is readable by software
// - lock signalling on data clock pin: high unlocked, low locked
// - programmed reset returns every configuration register to default
`timescale 1ns/1ps
module rfc_frontend
  import rfc_pkg::*;
#(
  parameter int ADDR_W = RFC_ADDR_W
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic sys_rst_in,
  // register port
  input wire logic [ADDR_W-1:0] cfg_addr_in,
  input wire logic cfg_wr_in,
  input wire logic cfg_rd_in,
  input wire logic [7:0] cfg_wdata_in,
  output logic [7:0] cfg_rdata_out,
  // analog core status (asynchronous)
  input wire logic tx_amp_on_in,
  input wire logic rx_amp_on_in,
  input wire logic synth_lock_in,
  // calibration engine and demodulator (same clock)
  input wire logic cal_done_in,
  input wire logic [3:0] charge_pump_cal_result_in,
  input wire logic [4:0] osc_array_cal_result_in,
  input wire logic [5:0] osc_bias_cal_result_in,
  input wire logic offset_valid_in,
  input wire logic [7:0] offset_value_in,
  input wire logic data_clock_src_in,
  // pins
  output logic tx_frontend_ctrl_out,
  output logic rx_frontend_ctrl_out,
  output logic lock_pin_out,
  output logic data_clock_pin_out,
  // synthesizer settings
  output logic [23:0] channel_word_out,
  output logic [3:0] charge_pump_setting_out,
  output logic [4:0] osc_array_setting_out,
  output logic [5:0] osc_bias_setting_out
);
  if (ADDR_W != RFC_ADDR_W) begin : g_chk
    $error("rfc_frontend: ADDR_W must equal 7");
  end

  logic [2:0] amp_sync;
  logic tx_on_s;
  logic rx_on_s;
  logic lock_s;
  logic [7:0] main_reg;
  logic [7:0] iface_reg;
  logic [7:0] lock_reg;
  logic [23:0] channel_word_first_reg;
  logic [23:0] channel_word_second_reg;
  logic [7:0] cp_force_reg;
  logic [7:0] oa_force_reg;
  logic [7:0] ob_force_reg;
  logic [3:0] cp_stat_reg;
  logic [4:0] oa_stat_reg;
  logic [5:0] ob_stat_reg;
  logic [7:0] offset_measure_reg;
  logic soft_rst_reg;
  logic [7:0] rdata_next;
  logic tx_next;
  logic rx_next;
  logic lock_next;

  rfc_sync2 #(.WIDTH(3)) u_sync (
    .clock_in(clock_in),
    .sys_rst_in(sys_rst_in),
    .async_in({synth_lock_in, rx_amp_on_in, tx_amp_on_in}),
    .sync_out(amp_sync)
  );
  assign tx_on_s = amp_sync[0];
  assign rx_on_s = amp_sync[1];
  assign lock_s = amp_sync[2];

  wire wr_main = cfg_wr_in && cfg_addr_in == RFC_MAIN_ADDR;
  wire wr_iface = cfg_wr_in && cfg_addr_in == RFC_IFACE_ADDR;
  wire tx_auto = iface_reg[RFC_IF_TX_AUTO_BIT];
  wire rx_auto = iface_reg[RFC_IF_RX_AUTO_BIT];
  wire tx_pol = iface_reg[RFC_IF_TX_POL_BIT];
  wire rx_pol = iface_reg[RFC_IF_RX_POL_BIT];
  wire data_clock_pin_lock_en = iface_reg[RFC_IF_DATA_CLOCK_PIN_LOCK_BIT];
  wire chan_sel = main_reg[RFC_MAIN_FSEL_BIT];
  wire [3:0] lock_sel = lock_reg[RFC_LOCK_SEL_W-1:0];
  wire cp_force_en = oa_force_reg[RFC_CP_FORCE_EN_BIT];
  wire oa_force_en = oa_force_reg[RFC_OA_FORCE_EN_BIT];
  wire ob_force_en = ob_force_reg[RFC_OB_FORCE_EN_BIT];

  // programmed reset: one-cycle pulse, applied on the following edge
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      soft_rst_reg <= 1'b0;
    end else begin
      soft_rst_reg <= cfg_wr_in && cfg_addr_in == RFC_RESET_ADDR && cfg_wdata_in[RFC_RESET_GO_BIT];
    end
  end

  // configuration registers; soft reset wins over a same-cycle write
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      main_reg <= RFC_REG_RST;
      iface_reg <= RFC_REG_RST;
      lock_reg <= RFC_REG_RST;
      cp_force_reg <= RFC_REG_RST;
      oa_force_reg <= RFC_REG_RST;
      ob_force_reg <= RFC_REG_RST;
    end else if (soft_rst_reg) begin
      main_reg <= RFC_REG_RST;
      iface_reg <= RFC_REG_RST;
      lock_reg <= RFC_REG_RST;
      cp_force_reg <= RFC_REG_RST;
      oa_force_reg <= RFC_REG_RST;
      ob_force_reg <= RFC_REG_RST;
    end else if (cfg_wr_in) begin
      case (cfg_addr_in)
        RFC_MAIN_ADDR: main_reg <= cfg_wdata_in;
        RFC_IFACE_ADDR: iface_reg <= cfg_wdata_in;
        RFC_LOCK_ADDR: lock_reg <= cfg_wdata_in;
        RFC_CP_FORCE_ADDR: cp_force_reg <= cfg_wdata_in;
        RFC_OA_FORCE_ADDR: oa_force_reg <= cfg_wdata_in;
        RFC_OB_FORCE_ADDR: ob_force_reg <= cfg_wdata_in;
        default: main_reg <= main_reg;
      endcase
    end
  end

  // both channel words stay writable so the idle one can be loaded for a hop
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      channel_word_first_reg <= RFC_CHAN_RST;
      channel_word_second_reg <= RFC_CHAN_RST;
    end else if (soft_rst_reg) begin
      channel_word_first_reg <= RFC_CHAN_RST;
      channel_word_second_reg <= RFC_CHAN_RST;
    end else if (cfg_wr_in) begin
      case (cfg_addr_in)
        RFC_FREQ2A_ADDR: channel_word_first_reg[23:16] <= cfg_wdata_in;
        RFC_FREQ1A_ADDR: channel_word_first_reg[15:8] <= cfg_wdata_in;
        RFC_FREQ0A_ADDR: channel_word_first_reg[7:0] <= cfg_wdata_in;
        RFC_FREQ2B_ADDR: channel_word_second_reg[23:16] <= cfg_wdata_in;
        RFC_FREQ1B_ADDR: channel_word_second_reg[15:8] <= cfg_wdata_in;
        RFC_FREQ0B_ADDR: channel_word_second_reg[7:0] <= cfg_wdata_in;
        default: channel_word_first_reg <= channel_word_first_reg;
      endcase
    end
  end

  // calibration results captured when a calibration completes
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cp_stat_reg <= '0;
      oa_stat_reg <= '0;
      ob_stat_reg <= '0;
    end else if (cal_done_in) begin
      cp_stat_reg <= charge_pump_cal_result_in;
      oa_stat_reg <= osc_array_cal_result_in;
      ob_stat_reg <= osc_bias_cal_result_in;
    end
  end

  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      offset_measure_reg <= RFC_REG_RST;
    end else if (offset_valid_in) begin
      offset_measure_reg <= offset_value_in;
    end
  end

  // synthesizer settings; forced values stand in for calibration results
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      channel_word_out <= RFC_CHAN_RST;
      charge_pump_setting_out <= '0;
      osc_array_setting_out <= '0;
      osc_bias_setting_out <= '0;
    end else begin
      channel_word_out <= chan_sel ? channel_word_second_reg : channel_word_first_reg;
      charge_pump_setting_out <= cp_force_en ? cp_force_reg[RFC_CP_W-1:0] : cp_stat_reg;
      osc_array_setting_out <= oa_force_en ? oa_force_reg[RFC_OA_W-1:0] : oa_stat_reg;
      osc_bias_setting_out <= ob_force_en ? ob_force_reg[RFC_OB_W-1:0] : ob_stat_reg;
    end
  end

  // pin values; all pins leave a flop so a write cannot glitch them
  always_comb begin
    tx_next = tx_auto ? (tx_on_s ? tx_pol : !tx_pol) : tx_pol;
    rx_next = rx_auto ? (rx_on_s ? rx_pol : !rx_pol) : rx_pol;
    case (lock_sel)
      RFC_LOCK_LOW: lock_next = 1'b0;
      RFC_LOCK_HIGH: lock_next = 1'b1;
      RFC_LOCK_SYNTH: lock_next = lock_s;
      default: lock_next = lock_s;
    endcase
  end

  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      tx_frontend_ctrl_out <= 1'b0;
      rx_frontend_ctrl_out <= 1'b0;
      lock_pin_out <= 1'b0;
      data_clock_pin_out <= 1'b0;
    end else begin
      tx_frontend_ctrl_out <= tx_next;
      rx_frontend_ctrl_out <= rx_next;
      lock_pin_out <= lock_next;
      data_clock_pin_out <= data_clock_pin_lock_en ? !lock_s : data_clock_src_in;
    end
  end

  // read data, one cycle after the strobe; unmapped addresses read zero
  always_comb begin
    case (cfg_addr_in)
      RFC_MAIN_ADDR: rdata_next = main_reg;
      RFC_IFACE_ADDR: rdata_next = iface_reg;
      RFC_FREQ2A_ADDR: rdata_next = channel_word_first_reg[23:16];
      RFC_FREQ1A_ADDR: rdata_next = channel_word_first_reg[15:8];
      RFC_FREQ0A_ADDR: rdata_next = channel_word_first_reg[7:0];
      RFC_FREQ2B_ADDR: rdata_next = channel_word_second_reg[23:16];
      RFC_FREQ1B_ADDR: rdata_next = channel_word_second_reg[15:8];
      RFC_FREQ0B_ADDR: rdata_next = channel_word_second_reg[7:0];
      RFC_LOCK_ADDR: rdata_next = lock_reg;
      RFC_OFFSET_ADDR: rdata_next = offset_measure_reg;
      RFC_CP_STAT_ADDR: rdata_next = {4'h0, cp_stat_reg};
      RFC_OA_STAT_ADDR: rdata_next = {3'h0, oa_stat_reg};
      RFC_OB_STAT_ADDR: rdata_next = {2'h0, ob_stat_reg};
      RFC_CP_FORCE_ADDR: rdata_next = cp_force_reg;
      RFC_OA_FORCE_ADDR: rdata_next = oa_force_reg;
      RFC_OB_FORCE_ADDR: rdata_next = ob_force_reg;
      default: rdata_next = 8'h00;
    endcase
  end

  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cfg_rdata_out <= 8'h00;
    end else if (cfg_rd_in) begin
      cfg_rdata_out <= rdata_next;
    end
  end

  // checks
  property p_tx_auto;
    @(posedge clock_in) disable iff (sys_rst_in)
    tx_auto && tx_on_s |=> tx_frontend_ctrl_out == $past(tx_pol);
  endproperty
  a_tx_auto: assert property (p_tx_auto) else $error("tx pin not active with amplifier on");

  property p_rx_auto;
    @(posedge clock_in) disable iff (sys_rst_in)
    rx_auto && rx_on_s |=> rx_frontend_ctrl_out == $past(rx_pol);
  endproperty
  a_rx_auto: assert property (p_rx_auto) else $error("rx pin not active with amplifier on");

  property p_pol_idle;
    @(posedge clock_in) disable iff (sys_rst_in)
    tx_auto && !tx_on_s |=> tx_frontend_ctrl_out != $past(tx_pol);
  endproperty
  a_pol_idle: assert property (p_pol_idle) else $error("tx pin inactive level wrong");

  property p_gpo;
    @(posedge clock_in) disable iff (sys_rst_in)
    !rx_auto |=> rx_frontend_ctrl_out == $past(rx_pol);
  endproperty
  a_gpo: assert property (p_gpo) else $error("rx pin not following its written bit");

  property p_lock_pin;
    @(posedge clock_in) disable iff (sys_rst_in)
    (lock_sel == RFC_LOCK_LOW || lock_sel == RFC_LOCK_HIGH) |=> lock_pin_out == $past(lock_sel[0]);
  endproperty
  a_lock_pin: assert property (p_lock_pin) else $error("lock pin not at selected constant");

  property p_chan;
    @(posedge clock_in) disable iff (sys_rst_in)
    chan_sel |=> channel_word_out == $past(channel_word_second_reg);
  endproperty
  a_chan: assert property (p_chan) else $error("second channel word not selected");

  property p_status;
    @(posedge clock_in) disable iff (sys_rst_in)
    cal_done_in |=> cp_stat_reg == $past(charge_pump_cal_result_in) && ob_stat_reg == $past(osc_bias_cal_result_in);
  endproperty
  a_status: assert property (p_status) else $error("calibration result not captured");

  property p_force;
    @(posedge clock_in) disable iff (sys_rst_in)
    oa_force_en |=> osc_array_setting_out == $past(oa_force_reg[RFC_OA_W-1:0]);
  endproperty
  a_force: assert property (p_force) else $error("forced array value not applied");

  property p_offset_rd;
    @(posedge clock_in) disable iff (sys_rst_in)
    cfg_rd_in && cfg_addr_in == RFC_OFFSET_ADDR |=> cfg_rdata_out == $past(offset_measure_reg);
  endproperty
  a_offset_rd: assert property (p_offset_rd) else $error("offset read wrong");

  property p_data_clock_pin_lock;
    @(posedge clock_in) disable iff (sys_rst_in)
    data_clock_pin_lock_en |=> data_clock_pin_out == !$past(lock_s);
  endproperty
  a_data_clock_pin_lock: assert property (p_data_clock_pin_lock) else $error("data clock pin lock level wrong");

  property p_soft_rst;
    @(posedge clock_in) disable iff (sys_rst_in)
    soft_rst_reg |=> main_reg == RFC_REG_RST && ob_force_reg == RFC_REG_RST && channel_word_second_reg == RFC_CHAN_RST;
  endproperty
  a_soft_rst: assert property (p_soft_rst) else $error("programmed reset left a register set");

  sequence s_gpo_write;
    wr_main == 1'b0 && wr_iface && !soft_rst_reg && !cfg_wdata_in[RFC_IF_TX_AUTO_BIT];
  endsequence
  property p_gpo_latency;
    @(posedge clock_in) disable iff (sys_rst_in)
    s_gpo_write ##1 !wr_iface |=> tx_frontend_ctrl_out == $past(cfg_wdata_in[RFC_IF_TX_POL_BIT], 2);
  endproperty
  a_gpo_latency: assert property (p_gpo_latency) else $error("pin late after register write");
endmodule : rfc_frontend

// ==== sim/rfc_analog_model.sv ====
// rfc_analog_model: behavioural analog core, calibration engine and demodulator.
// assumes the bench calls its tasks just after a rising edge of clock_in.
`timescale 1ns/1ps
module rfc_analog_model (
  // clock
  input wire logic clock_in,
  // amplifier, synthesizer and data clock levels
  output logic tx_amp_on_out,
  output logic rx_amp_on_out,
  output logic synth_lock_out,
  output logic data_clock_out,
  // calibration and offset results
  output logic cal_done_out,
  output logic [3:0] cp_out,
  output logic [4:0] oa_out,
  output logic [5:0] ob_out,
  output logic offset_valid_out,
  output logic [7:0] offset_out
);
  initial begin
    tx_amp_on_out = 1'b0;
    rx_amp_on_out = 1'b0;
    synth_lock_out = 1'b0;
    data_clock_out = 1'b0;
    cal_done_out = 1'b0;
    cp_out = 4'h0;
    oa_out = 5'h00;
    ob_out = 6'h00;
    offset_valid_out = 1'b0;
    offset_out = 8'h00;
  end

  task automatic set_levels(input logic tx, input logic rx, input logic lock, input logic data_clock_pin);
    tx_amp_on_out = tx;
    rx_amp_on_out = rx;
    synth_lock_out = lock;
    data_clock_out = data_clock_pin;
  endtask : set_levels

  // results valid only in the strobe cycle; inverted after so a late capture shows
  task automatic calibrate(input logic [3:0] cp, input logic [4:0] oa, input logic [5:0] ob);
    cp_out = cp;
    oa_out = oa;
    ob_out = ob;
    cal_done_out = 1'b1;
    @(posedge clock_in);
    #1;
    cal_done_out = 1'b0;
    cp_out = ~cp;
    oa_out = ~oa;
    ob_out = ~ob;
  endtask : calibrate

  task automatic measure(input logic [7:0] v);
    offset_out = v;
    offset_valid_out = 1'b1;
    @(posedge clock_in);
    #1;
    offset_valid_out = 1'b0;
    offset_out = ~v;
  endtask : measure
endmodule : rfc_analog_model

// ==== sim/rfc_frontend_test.sv ====
// rfc_frontend_test: register-level test of the front-end pin and hop block.
// assumes one 10 MHz clock and the analog model beside the block.
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin num_checks++; if ((gt) !== (ex)) begin err_count++; \
  $display("ERROR %s expected %h seen %h", nm, ex, gt); end end
module rfc_frontend_test;
  import rfc_pkg::*;
  logic clock_in;
  logic sys_rst_in;
  logic [6:0] cfg_addr_in;
  logic cfg_wr_in;
  logic cfg_rd_in;
  logic [7:0] cfg_wdata_in;
  logic [7:0] cfg_rdata_out;
  logic tx_on, rx_on, lock, data_clock_pin, cal_done, off_valid;
  logic [3:0] cp;
  logic [4:0] oa;
  logic [5:0] ob;
  logic [7:0] off_val;
  logic tx_pin, rx_pin, lock_pin, data_clock_pin_pin;
  logic [23:0] chan;
  logic [3:0] cp_set;
  logic [4:0] oa_set;
  logic [5:0] ob_set;
  int err_count = 0;
  int num_checks = 0;
  logic [6:0] dflt [8] = '{RFC_MAIN_ADDR, RFC_IFACE_ADDR, RFC_LOCK_ADDR, RFC_FREQ2A_ADDR,
                           RFC_FREQ0B_ADDR, RFC_CP_STAT_ADDR, RFC_OA_FORCE_ADDR, 7'h7F};

  rfc_frontend rfc_frontend_i (.clock_in(clock_in), .sys_rst_in(sys_rst_in), .cfg_addr_in(cfg_addr_in),
    .cfg_wr_in(cfg_wr_in), .cfg_rd_in(cfg_rd_in), .cfg_wdata_in(cfg_wdata_in), .cfg_rdata_out(cfg_rdata_out),
    .tx_amp_on_in(tx_on), .rx_amp_on_in(rx_on), .synth_lock_in(lock), .cal_done_in(cal_done),
    .charge_pump_cal_result_in(cp), .osc_array_cal_result_in(oa), .osc_bias_cal_result_in(ob),
    .offset_valid_in(off_valid), .offset_value_in(off_val), .data_clock_src_in(data_clock_pin),
    .tx_frontend_ctrl_out(tx_pin), .rx_frontend_ctrl_out(rx_pin), .lock_pin_out(lock_pin),
    .data_clock_pin_out(data_clock_pin_pin), .channel_word_out(chan), .charge_pump_setting_out(cp_set),
    .osc_array_setting_out(oa_set), .osc_bias_setting_out(ob_set));

  rfc_analog_model rfc_analog_model_i (.clock_in(clock_in), .tx_amp_on_out(tx_on), .rx_amp_on_out(rx_on),
    .synth_lock_out(lock), .data_clock_out(data_clock_pin), .cal_done_out(cal_done), .cp_out(cp), .oa_out(oa),
    .ob_out(ob), .offset_valid_out(off_valid), .offset_out(off_val));

  // each access starts one edge later, so a strobe is never dropped and raised in one step
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge clock_in);
    #1;
    cfg_addr_in = a;
    cfg_wdata_in = d;
    cfg_wr_in = 1'b1;
    @(posedge clock_in);
    #1;
    cfg_wr_in = 1'b0;
  endtask : wr

  task automatic rd_chk(input logic [6:0] a, input logic [7:0] ex);
    @(posedge clock_in);
    #1;
    cfg_addr_in = a;
    cfg_rd_in = 1'b1;
    @(posedge clock_in);
    #1;
    cfg_rd_in = 1'b0;
    `CHK("rdata", ex, cfg_rdata_out)
  endtask : rd_chk

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask : wait_cyc

  task automatic results();
    if (err_count == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : results

  initial begin
    clock_in = 1'b0;
    forever #50 clock_in = ~clock_in;
  end

  // whole sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clock_in);
    err_count++;
    results();
  end

  initial begin
    sys_rst_in = 1'b1;
    cfg_addr_in = 7'h00;
    cfg_wr_in = 1'b0;
    cfg_rd_in = 1'b0;
    cfg_wdata_in = 8'h00;
    repeat (16) @(posedge clock_in);
    #1;
    sys_rst_in = 1'b0;
    foreach (dflt[i]) rd_chk(dflt[i], 8'h00);
    `CHK("lock_pin", 1'b0, lock_pin)
    wr(RFC_IFACE_ADDR, 8'h04);
    wait_cyc(1);
    `CHK("tx_pin", 1'b1, tx_pin)
    `CHK("rx_pin", 1'b0, rx_pin)
    wr(RFC_IFACE_ADDR, 8'h08);
    wait_cyc(1);
    `CHK("tx_pin", 1'b0, tx_pin)
    `CHK("rx_pin", 1'b1, rx_pin)
    for (int p = 0; p < 2; p++) begin
      for (int a = 0; a < 2; a++) begin
        wr(RFC_IFACE_ADDR, p[0] ? 8'h0F : 8'h03);
        rfc_analog_model_i.set_levels(a[0], !a[0], 1'b0, 1'b0);
        wait_cyc(4);
        `CHK("tx_pin", a[0] ? p[0] : !p[0], tx_pin)
        `CHK("rx_pin", a[0] ? !p[0] : p[0], rx_pin)
      end
    end
    rfc_analog_model_i.set_levels(1'b0, 1'b0, 1'b0, 1'b0);
    wr(RFC_LOCK_ADDR, 8'h01);
    wait_cyc(4);
    `CHK("lock_pin", 1'b1, lock_pin)
    rfc_analog_model_i.set_levels(1'b0, 1'b0, 1'b1, 1'b0);
    wr(RFC_LOCK_ADDR, 8'h02);
    wait_cyc(4);
    `CHK("lock_pin", 1'b1, lock_pin)
    wr(RFC_LOCK_ADDR, 8'h00);
    wait_cyc(4);
    `CHK("lock_pin", 1'b0, lock_pin)
    wr(RFC_IFACE_ADDR, 8'h10);
    wait_cyc(4);
    `CHK("data_clock_pin_pin", 1'b0, data_clock_pin_pin)
    rfc_analog_model_i.set_levels(1'b0, 1'b0, 1'b0, 1'b0);
    wait_cyc(4);
    `CHK("data_clock_pin_pin", 1'b1, data_clock_pin_pin)
    rfc_analog_model_i.set_levels(1'b0, 1'b0, 1'b1, 1'b1);
    wr(RFC_IFACE_ADDR, 8'h00);
    wait_cyc(4);
    `CHK("data_clock_pin_pin", 1'b1, data_clock_pin_pin)
    wr(RFC_FREQ2A_ADDR, 8'h12);
    wr(RFC_FREQ1A_ADDR, 8'h34);
    wr(RFC_FREQ0A_ADDR, 8'h56);
    wr(RFC_FREQ2B_ADDR, 8'h65);
    wr(RFC_FREQ1B_ADDR, 8'h43);
    wr(RFC_FREQ0B_ADDR, 8'h21);
    wait_cyc(2);
    `CHK("chan", 24'h12_3456, chan)
    rfc_analog_model_i.calibrate(4'h3, 5'h11, 6'h2A);
    rd_chk(RFC_CP_STAT_ADDR, 8'h03);
    rd_chk(RFC_OA_STAT_ADDR, 8'h11);
    rd_chk(RFC_OB_STAT_ADDR, 8'h2A);
    rfc_analog_model_i.set_levels(1'b0, 1'b0, 1'b1, 1'b0);
    wr(RFC_MAIN_ADDR, 8'h40);
    wait_cyc(2);
    `CHK("chan", 24'h65_4321, chan)
    rfc_analog_model_i.calibrate(4'h9, 5'h0E, 6'h2A);
    wait_cyc(2);
    `CHK("cp_set", 4'h9, cp_set)
    `CHK("oa_set", 5'h0E, oa_set)
    wr(RFC_MAIN_ADDR, 8'h00);
    wr(RFC_CP_FORCE_ADDR, 8'h03);
    wr(RFC_OA_FORCE_ADDR, 8'h71);
    wr(RFC_OB_FORCE_ADDR, 8'h55);
    wait_cyc(2);
    `CHK("chan", 24'h12_3456, chan)
    `CHK("cp_set", 4'h3, cp_set)
    `CHK("oa_set", 5'h11, oa_set)
    `CHK("ob_set", 6'h15, ob_set)
    rd_chk(RFC_OA_FORCE_ADDR, 8'h71);
    wr(RFC_OA_FORCE_ADDR, 8'h31);
    wait_cyc(2);
    `CHK("cp_set", 4'h9, cp_set)
    `CHK("oa_set", 5'h11, oa_set)
    wr(RFC_OA_FORCE_ADDR, 8'h00);
    wr(RFC_OB_FORCE_ADDR, 8'h00);
    wait_cyc(2);
    `CHK("oa_set", 5'h0E, oa_set)
    `CHK("ob_set", 6'h2A, ob_set)
    wr(RFC_CP_STAT_ADDR, 8'hFF);
    rd_chk(RFC_CP_STAT_ADDR, 8'h09);
    rfc_analog_model_i.measure(8'hA5);
    rd_chk(RFC_OFFSET_ADDR, 8'hA5);
    wr(RFC_IFACE_ADDR, 8'h0C);
    wr(RFC_RESET_ADDR, 8'h01);
    wait_cyc(3);
    rd_chk(RFC_IFACE_ADDR, 8'h00);
    rd_chk(RFC_CP_FORCE_ADDR, 8'h00);
    rd_chk(RFC_FREQ2B_ADDR, 8'h00);
    rd_chk(RFC_CP_STAT_ADDR, 8'h09);
    `CHK("tx_pin", 1'b0, tx_pin)
    results();
  end
endmodule : rfc_frontend_test
